// >>> hw/tst_timer_block.sv
`timescale 1ns/1ps
module tst_timer_block
  import tst_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                resetn,
  input  wire logic                reg_req,
  input  wire logic                reg_write,
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [15:0]         reg_wdata,
  output logic      [15:0]         reg_rdata,
  output logic                     reg_stall,
  input  wire logic [PIN_TIMERS-1:0] timer_in,
  output logic      [PIN_TIMERS-1:0] timer_out,
  output logic      [NUM_TIMERS-1:0] timer_irq
);

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic tst_reg_kind_t reg_kind(input logic [7:0] addr,
                                             input logic [1:0] tmr);
    reg_kind = TST_REG_NONE;
    case (tmr)
      2'h0: begin
        case (addr)
          T0_COUNT_OFS:   reg_kind = TST_REG_COUNT;
          T0_LIMIT_A_OFS: reg_kind = TST_REG_LIMIT_A;
          T0_LIMIT_B_OFS: reg_kind = TST_REG_LIMIT_B;
          T0_CONTROL_OFS: reg_kind = TST_REG_CONTROL;
          default:        reg_kind = TST_REG_NONE;
        endcase
      end
      2'h1: begin
        case (addr)
          T1_COUNT_OFS:   reg_kind = TST_REG_COUNT;
          T1_LIMIT_A_OFS: reg_kind = TST_REG_LIMIT_A;
          T1_LIMIT_B_OFS: reg_kind = TST_REG_LIMIT_B;
          T1_CONTROL_OFS: reg_kind = TST_REG_CONTROL;
          default:        reg_kind = TST_REG_NONE;
        endcase
      end
      2'h2: begin
        case (addr)
          T2_COUNT_OFS:   reg_kind = TST_REG_COUNT;
          T2_LIMIT_A_OFS: reg_kind = TST_REG_LIMIT_A;
          T2_CONTROL_OFS: reg_kind = TST_REG_CONTROL;
          default:        reg_kind = TST_REG_NONE;
        endcase
      end
      default: reg_kind = TST_REG_NONE;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Register port with one wait state
  // ---------------------------------------------------------------
  logic        waited;
  logic        wr_commit;
  logic        rd_capture;
  logic [15:0] rd_word;

  // Every access is stalled for its first cycle; it completes in the
  // second, so a held request always sees exactly one wait state.
  assign reg_stall  = reg_req & ~waited;                      // [RL7] [RL25]
  assign rd_capture = reg_req & ~waited;
  assign wr_commit  = reg_req & reg_write & waited;           // [RL7]

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      waited <= 1'b0;
    end else if (reg_req && !waited) begin
      waited <= 1'b1;
    end else begin
      waited <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (rd_capture) begin
      reg_rdata <= rd_word;
    end
  end

  // ---------------------------------------------------------------
  // Service slot sequencer
  // ---------------------------------------------------------------
  logic [1:0] phase;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      phase <= 2'h0;
    end else if (phase == SVC_LAST_SLOT) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // Per-timer state
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] count   [NUM_TIMERS];
  logic [CNT_W-1:0] limit_a [NUM_TIMERS];
  logic [CNT_W-1:0] limit_b [NUM_TIMERS];
  logic [15:0]      ctl_word[NUM_TIMERS];
  logic [NUM_TIMERS-1:0] hit;
  logic             t2_hit;

  assign t2_hit = hit[2];

  always_comb begin
    tst_reg_kind_t k;
    k       = TST_REG_NONE;
    rd_word = 16'h0000;
    for (int t = 0; t < NUM_TIMERS; t++) begin
      k = reg_kind(reg_addr, 2'(t));
      case (k)
        TST_REG_COUNT:   rd_word = count[t];                  // [RL1]
        TST_REG_LIMIT_A: rd_word = limit_a[t];
        TST_REG_LIMIT_B: rd_word = limit_b[t];
        TST_REG_CONTROL: rd_word = ctl_word[t];
        default:         rd_word = rd_word;
      endcase
    end
  end

  for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_tmr
    localparam logic       HAS_PINS = (i < PIN_TIMERS);
    localparam logic [1:0] MY_SLOT  = 2'(i);

    tst_reg_kind_t    kind;
    logic             wr_count;
    logic             wr_lim_a;
    logic             wr_lim_b;
    logic             wr_ctl;
    logic             svc;
    logic             run_gate;
    logic             irq_en;
    logic             active_limit_flag;
    logic             limit_reached_flag;
    logic             edge_restart_select;
    logic             chain_source_select;
    logic             outside_clock_select;
    logic             dual_limit_mode;
    logic             free_run;
    logic             started;
    logic             pin_lvl;
    logic             pin_edge;
    logic             edge_pend;
    logic             chain_pend;
    logic             edge_seen;
    logic             tick;
    logic             restart;
    logic             step;
    logic             halt;
    logic [CNT_W-1:0] cnt_inc;
    logic [CNT_W-1:0] active_limit;

    assign kind     = reg_kind(reg_addr, MY_SLOT);
    assign wr_count = wr_commit & (kind == TST_REG_COUNT);
    assign wr_lim_a = wr_commit & (kind == TST_REG_LIMIT_A);
    assign wr_lim_b = wr_commit & (kind == TST_REG_LIMIT_B);
    assign wr_ctl   = wr_commit & (kind == TST_REG_CONTROL);
    assign svc      = (phase == MY_SLOT);                     // [RL5]

    // -------------------------------------------------------------
    // Input pin synchroniser
    // -------------------------------------------------------------
    if (HAS_PINS) begin : g_pin
      logic sync1;
      logic sync2;
      logic prev;
      logic tout;

      // Pin passes two flops; the edge detector compares the second with a third flop, prev.
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          sync1 <= 1'b0;
          sync2 <= 1'b0;
          prev  <= 1'b0;
        end else begin
          sync1 <= timer_in[i];
          sync2 <= sync1;
          prev  <= sync2;
        end
      end

      assign pin_lvl  = sync2;
      assign pin_edge = sync2 & ~prev;

      // Output changes on the service edge that saw the limit.
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          tout <= 1'b1;                                       // [RL24]
        end else if (dual_limit_mode) begin
          tout <= ~(active_limit_flag ^ (hit[i] & svc));      // [RL4]
        end else begin
          tout <= ~hit[i];                                    // [RL3] [RL6]
        end
      end

      assign timer_out[i] = tout;
    end else begin : g_nopin
      assign pin_lvl  = 1'b1;
      assign pin_edge = 1'b0;
    end

    // -------------------------------------------------------------
    // Pending events between service slots
    // -------------------------------------------------------------
    // An edge is held until this timer's slot; one arriving in the slot
    // itself is used directly, so edges four clocks apart are kept.
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        edge_pend <= 1'b0;
      end else if (!run_gate) begin
        edge_pend <= 1'b0;                                    // [RL8]
      end else if (svc) begin
        edge_pend <= 1'b0;
      end else begin
        edge_pend <= edge_pend | pin_edge;                    // [RL18]
      end
    end

    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        chain_pend <= 1'b0;
      end else if (!run_gate || svc) begin
        chain_pend <= 1'b0;
      end else begin
        chain_pend <= chain_pend | t2_hit;                    // [RL17]
      end
    end

    assign edge_seen = edge_pend | pin_edge;

    // -------------------------------------------------------------
    // Count advance decision
    // -------------------------------------------------------------
    always_comb begin
      restart = 1'b0;
      if (outside_clock_select) begin
        tick = edge_seen;                                     // [RL18]
      end else if (edge_restart_select) begin
        restart = edge_seen;                                  // [RL16]
        tick    = started & (chain_source_select ?
                             chain_pend : 1'b1);
      end else begin
        tick = pin_lvl & (chain_source_select ?               // [RL15]
                          chain_pend : 1'b1);                 // [RL17]
      end
    end

    assign active_limit = active_limit_flag ? limit_b[i]      // [RL19]
                                            : limit_a[i];
    assign cnt_inc = count[i] + 16'h0001;
    assign step    = svc & run_gate & tick & ~restart;        // [RL8]
    // Only an exact match wraps, so a limit below the count rolls over.
    assign hit[i]  = step & (cnt_inc == active_limit);        // [RL2] [RL23]
    assign halt    = hit[i] & ~free_run &
                     (~dual_limit_mode | active_limit_flag);  // [RL9] [RL20]

    // -------------------------------------------------------------
    // Count and limit registers
    // -------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        count[i] <= CNT_RESET;
      end else if (wr_count) begin
        count[i] <= reg_wdata;                                // [RL1] [RL22]
      end else if (svc && run_gate && restart) begin
        count[i] <= CNT_RESET;                                // [RL16]
      end else if (hit[i]) begin
        count[i] <= CNT_RESET;                                // [RL2]
      end else if (step) begin
        count[i] <= cnt_inc;                                  // [RL1]
      end
    end

    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        limit_a[i] <= LIMIT_RESET;
      end else if (wr_lim_a) begin
        limit_a[i] <= reg_wdata;
      end
    end

    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        limit_b[i] <= LIMIT_RESET;
      end else if (wr_lim_b && HAS_PINS) begin
        limit_b[i] <= reg_wdata;                              // [RL21]
      end
    end

    // -------------------------------------------------------------
    // Control word
    // -------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        run_gate <= 1'b0;                                     // [RL24]
      end else if (wr_ctl && reg_wdata[CTL_QUALIFY_BIT]) begin
        run_gate <= reg_wdata[CTL_RUN_GATE_BIT];              // [RL10]
      end else if (halt) begin
        run_gate <= 1'b0;                                     // [RL9]
      end
    end

    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        irq_en               <= 1'b0;
        edge_restart_select  <= 1'b0;
        chain_source_select  <= 1'b0;
        outside_clock_select <= 1'b0;
        dual_limit_mode      <= HAS_PINS & PIN_DUAL_RESET;    // [RL24]
        free_run             <= 1'b0;
      end else if (wr_ctl) begin
        irq_en               <= reg_wdata[CTL_IRQ_EN_BIT];
        edge_restart_select  <= HAS_PINS &                    // [RL21]
                                reg_wdata[CTL_RESTART_BIT];
        chain_source_select  <= HAS_PINS &
                                reg_wdata[CTL_CHAIN_BIT];
        outside_clock_select <= HAS_PINS &
                                reg_wdata[CTL_OUTSIDE_BIT];
        dual_limit_mode      <= HAS_PINS &
                                reg_wdata[CTL_DUAL_BIT];
        free_run             <= reg_wdata[CTL_FREE_RUN_BIT];
      end
    end

    // A limit reached in the same cycle as a clearing write still sets.
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        limit_reached_flag <= 1'b0;
      end else if (hit[i]) begin
        limit_reached_flag <= 1'b1;                           // [RL14]
      end else if (wr_ctl) begin
        limit_reached_flag <= reg_wdata[CTL_REACHED_BIT];     // [RL14]
      end
    end

    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        active_limit_flag <= 1'b0;                            // [RL24]
      end else if (!dual_limit_mode || !HAS_PINS) begin
        active_limit_flag <= 1'b0;                            // [RL13]
      end else if (wr_ctl && !reg_wdata[CTL_DUAL_BIT]) begin
        active_limit_flag <= 1'b0;                            // [RL13]
      end else if (hit[i]) begin
        active_limit_flag <= ~active_limit_flag;              // [RL19]
      end
    end

    // Retrigger mode waits for its first rising edge after enabling.
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        started <= 1'b0;
      end else if (!run_gate || wr_ctl) begin
        started <= 1'b0;
      end else if (svc && restart) begin
        started <= 1'b1;                                      // [RL16]
      end
    end

    // -------------------------------------------------------------
    // Interrupt request pulse
    // -------------------------------------------------------------
    // One pulse per terminal count; the controller outside latches it.
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        timer_irq[i] <= 1'b0;
      end else begin
        timer_irq[i] <= hit[i] & irq_en;                      // [RL11] [RL12]
      end
    end

    always_comb begin
      ctl_word[i] = 16'h0000;
      ctl_word[i][CTL_RUN_GATE_BIT] = run_gate;
      ctl_word[i][CTL_IRQ_EN_BIT]   = irq_en;
      ctl_word[i][CTL_ACTIVE_BIT]   = active_limit_flag;      // [RL13]
      ctl_word[i][CTL_REACHED_BIT]  = limit_reached_flag;
      ctl_word[i][CTL_RESTART_BIT]  = edge_restart_select;
      ctl_word[i][CTL_CHAIN_BIT]    = chain_source_select;
      ctl_word[i][CTL_OUTSIDE_BIT]  = outside_clock_select;
      ctl_word[i][CTL_DUAL_BIT]     = dual_limit_mode;
      ctl_word[i][CTL_FREE_RUN_BIT] = free_run;
    end
  end

endmodule

// >>> shared/tst_pkg.sv
// Behaviour
// (RL1) Sixteen-bit count, readable and writable any time.
// (RL2) Count returns to zero on reaching limit.
// (RL3) Single limit: output low one clock after.
// (RL4) Dual limit: output low for B, high A.
// (RL5) Each timer serviced once every fourth clock.
// (RL6) Output responds within six clocks of input.
// (RL7) Every register access gets one wait state.
// (RL8) run_gate clear stops counting, ignores pins.
// (RL9) free_run clear halts timer at maximum count.
// (RL10) run_gate written only when write_qualify_run set.
// (RL11) Interrupt request raised at every terminal count.
// (RL12) Issued request stays latched downstream until serviced.
// (RL13) active_limit_flag shows limit, read-only, zero single.
// (RL14) limit_reached_flag sticky until software clears it.
// (RL15) Level gating: count while pin high.
// (RL16) Retrigger: rising edge clears count and starts.
// (RL17) Prescale selects quarter clock or timer two.
// (RL18) External clock counts edges four clocks apart.
// (RL19) Dual limit alternates A and B; else A.
// (RL20) One-shot dual: A, wrap, B, wrap, halt.
// (RL21) Timer two: one limit, mode bits zero.
// (RL22) Count write takes effect in current cycle.
// (RL23) Limit below count: roll over through all-ones.
// (RL24) Reset clears run_gate, sets dual_limit_mode pins.
// (RL25) Word register port with stall for wait state.
package tst_pkg;

  localparam int unsigned NUM_TIMERS = 3;
  localparam int unsigned PIN_TIMERS = 2;
  localparam int unsigned CNT_W      = 16;
  localparam int unsigned ADDR_W     = 8;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] T0_COUNT_OFS   = 8'h50;
  localparam logic [7:0] T0_LIMIT_A_OFS = 8'h52;
  localparam logic [7:0] T0_LIMIT_B_OFS = 8'h54;
  localparam logic [7:0] T0_CONTROL_OFS = 8'h56;
  localparam logic [7:0] T1_COUNT_OFS   = 8'h58;
  localparam logic [7:0] T1_LIMIT_A_OFS = 8'h5a;
  localparam logic [7:0] T1_LIMIT_B_OFS = 8'h5c;
  localparam logic [7:0] T1_CONTROL_OFS = 8'h5e;
  localparam logic [7:0] T2_COUNT_OFS   = 8'h60;
  localparam logic [7:0] T2_LIMIT_A_OFS = 8'h62;
  localparam logic [7:0] T2_CONTROL_OFS = 8'h66;

  // ---------------------------------------------------------------
  // Control word fields
  // ---------------------------------------------------------------
  localparam int unsigned CTL_RUN_GATE_BIT  = 15;
  localparam int unsigned CTL_QUALIFY_BIT   = 14;
  localparam int unsigned CTL_IRQ_EN_BIT    = 13;
  localparam int unsigned CTL_ACTIVE_BIT    = 12;
  localparam int unsigned CTL_REACHED_BIT   = 5;
  localparam int unsigned CTL_RESTART_BIT   = 4;
  localparam int unsigned CTL_CHAIN_BIT     = 3;
  localparam int unsigned CTL_OUTSIDE_BIT   = 2;
  localparam int unsigned CTL_DUAL_BIT      = 1;
  localparam int unsigned CTL_FREE_RUN_BIT  = 0;

  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [15:0] CNT_RESET      = 16'h0000;
  localparam logic [15:0] LIMIT_RESET    = 16'h0000;
  localparam logic        PIN_DUAL_RESET = 1'b1;
  localparam logic [1:0]  SVC_LAST_SLOT  = 2'h3;
  localparam int unsigned SYNC_STAGES    = 2;

  typedef enum logic [2:0] {
    TST_REG_NONE    = 3'h0,
    TST_REG_COUNT   = 3'h1,
    TST_REG_LIMIT_A = 3'h3,
    TST_REG_LIMIT_B = 3'h2,
    TST_REG_CONTROL = 3'h6
  } tst_reg_kind_t;

endpackage

// >>> tb/tst_timer_properties.sv
`timescale 1ns/1ps
module tst_timer_properties
  import tst_pkg::*;
(
  input wire logic                  clock,
  input wire logic                  resetn,
  input wire logic                  reg_req,
  input wire logic                  reg_write,
  input wire logic [ADDR_W-1:0]     reg_addr,
  input wire logic [15:0]           reg_wdata,
  input wire logic [15:0]           reg_rdata,
  input wire logic                  reg_stall,
  input wire logic [PIN_TIMERS-1:0] timer_in,
  input wire logic [PIN_TIMERS-1:0] timer_out,
  input wire logic [NUM_TIMERS-1:0] timer_irq
);
  // ------------------------------------------------------------
  // Timer 0 mode, followed from completed control writes.
  // ------------------------------------------------------------
  logic dual0;
  logic rd_go;
  assign rd_go = reg_req && !reg_write && reg_stall;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dual0 <= PIN_DUAL_RESET;
    end else if (reg_req && reg_write && !reg_stall
                 && reg_addr == T0_CONTROL_OFS) begin
      dual0 <= reg_wdata[CTL_DUAL_BIT];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_stall;
    reg_req && reg_stall;
  endsequence
  sequence s_done;
    reg_req && !reg_stall;
  endsequence
  AST_STALL_FIRST: assert property ($rose(reg_req) |-> s_stall)
    else $error("no wait state at access start");
  AST_STALL_ONCE: assert property (s_stall |=> s_done)
    else $error("wait state not one cycle");
  AST_RDATA_HOLD: assert property (
    !(reg_req && reg_stall) |=> $stable(reg_rdata))
    else $error("read data moved outside an access");
  AST_UNMAPPED_ZERO: assert property (
    rd_go && (reg_addr == 8'h64 || reg_addr[0]) |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_QUALIFY_ZERO: assert property (
    rd_go && reg_addr[2:0] == 3'h6 |=> !reg_rdata[CTL_QUALIFY_BIT])
    else $error("qualify bit read as one");
  AST_T2_FIXED: assert property (
    rd_go && reg_addr == T2_CONTROL_OFS
    |=> reg_rdata[12] == 1'b0 && reg_rdata[4:1] == 4'h0)
    else $error("timer 2 fixed bits not zero");
  AST_ACTIVE_SINGLE: assert property (
    rd_go && reg_addr == T0_CONTROL_OFS && !dual0
    |=> !reg_rdata[CTL_ACTIVE_BIT])
    else $error("active flag set in single mode");
  AST_T0_PULSE: assert property (
    !dual0 && $fell(timer_out[0]) |=> timer_out[0])
    else $error("single mode pulse wider than one clock");
  AST_IRQ_SPACING: assert property (
    timer_irq[2] |=> !timer_irq[2] [*3])
    else $error("timer 2 serviced more than once in four clocks");
  AST_RESET_PINS: assert property (
    $rose(resetn) |-> timer_out == 2'h3 && timer_irq == 3'h0)
    else $error("pins wrong after reset");
endmodule

bind tst_timer_block tst_timer_properties tst_timer_properties_i (
  .clock(clock), .resetn(resetn), .reg_req(reg_req),
  .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_stall(reg_stall), .timer_in(timer_in),
  .timer_out(timer_out), .timer_irq(timer_irq)
);

// >>> tb/tst_pin_model.sv
`timescale 1ns/1ps
module tst_pin_model
  import tst_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic [PIN_TIMERS-1:0] pulse_en,
  input  wire logic [PIN_TIMERS-1:0] level,
  input  wire logic [7:0]            gap,
  output logic      [PIN_TIMERS-1:0] timer_in,
  output logic      [15:0]           edge_count
);
  // ------------------------------------------------------------
  // Event source, rising edges spaced by gap clocks, never fewer than four.
  // ------------------------------------------------------------
  logic [7:0] phase;
  logic [7:0] span;
  assign span = (gap < 8'h04) ? 8'h04 : gap;
  initial begin
    phase = 8'h00;
    timer_in = '0;
    edge_count = 16'h0000;
  end
  always @(posedge clock) begin
    if (pulse_en == '0 || phase == span - 8'h01) begin
      phase <= 8'h00;
    end else begin
      phase <= phase + 8'h01;
    end
    for (int i = 0; i < PIN_TIMERS; i++) begin
      timer_in[i] <= pulse_en[i] ? (phase < 8'h02) : level[i];
    end
    if (pulse_en[0] && phase == 8'h00) begin
      edge_count <= edge_count + 16'h0001;
    end
  end
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
  import tst_pkg::*;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] data;
  } tst_row_t;
  localparam int LIMIT = 20000;
  logic                  clock = 1'b0;
  logic                  resetn = 1'b0;
  logic                  reg_req = 1'b0;
  logic                  reg_write = 1'b0;
  logic [ADDR_W-1:0]     reg_addr = 8'h00;
  logic [15:0]           reg_wdata = 16'h0000;
  logic [15:0]           reg_rdata;
  logic                  reg_stall;
  logic [PIN_TIMERS-1:0] timer_in;
  logic [PIN_TIMERS-1:0] timer_out;
  logic [NUM_TIMERS-1:0] timer_irq;
  logic [PIN_TIMERS-1:0] pulse_en = 2'h0;
  logic [PIN_TIMERS-1:0] level = 2'h0;
  logic [7:0]            gap = 8'h04;
  logic [15:0]           edge_count;
  logic [15:0]           v;
  logic [15:0]           w;
  int                    fails = 0;
  int                    tests_run = 0;
  int                    cycles = 0;
  int                    lows;
  int                    irqs;
  tst_row_t rows [17] = '{
    '{1'b1, 8'h52, 16'h1234}, '{1'b0, 8'h52, 16'h1234},
    '{1'b1, 8'h54, 16'habcd}, '{1'b0, 8'h54, 16'habcd},
    '{1'b1, 8'h50, 16'h0005}, '{1'b0, 8'h50, 16'h0005},
    '{1'b1, 8'h64, 16'hffff}, '{1'b0, 8'h64, 16'h0000},
    '{1'b1, 8'h66, 16'h401e}, '{1'b0, 8'h66, 16'h0000},
    '{1'b1, 8'h56, 16'h8002}, '{1'b0, 8'h56, 16'h0002},
    '{1'b1, 8'h56, 16'h1002}, '{1'b0, 8'h56, 16'h0002},
    '{1'b1, 8'h5e, 16'h4000}, '{1'b0, 8'h5e, 16'h0000},
    '{1'b0, 8'h51, 16'h0000}};

  always #50 clock = ~clock;

  tst_timer_block tst_timer_block_i (
    .clock(clock), .resetn(resetn), .reg_req(reg_req),
    .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_stall(reg_stall), .timer_in(timer_in),
    .timer_out(timer_out), .timer_irq(timer_irq)
  );
  tst_pin_model tst_pin_model_i (
    .clock(clock), .pulse_en(pulse_en), .level(level), .gap(gap),
    .timer_in(timer_in), .edge_count(edge_count)
  );

  task automatic finish_test();
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      finish_test();
    end
  end

  task automatic tick();
    @(posedge clock);
    #1;
  endtask

  task automatic check(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [15:0] d, output logic [15:0] q);
    logic s0;
    reg_req = 1'b1;
    reg_write = wr;
    reg_addr = a;
    reg_wdata = d;
    #1;
    s0 = reg_stall;
    tick();
    q = reg_rdata;
    check("stall", 16'h0002, {14'h0, s0, reg_stall});
    tick();
    reg_req = 1'b0;
    tick();
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    access(1'b1, a, d, v);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    access(1'b0, a, 16'h0000, v);
    check($sformatf("reg_%h", a), e, v);
  endtask

  // Counts interrupt pulses of timer k and low output cycles of pin k[0].
  task automatic watch(input int k, input int m);
    lows = 0;
    irqs = 0;
    repeat (m) begin
      tick();
      if (timer_irq[k] === 1'b1) irqs++;
      if (timer_out[k[0]] === 1'b0) lows++;
    end
  endtask

  initial begin
    repeat (16) tick();
    resetn = 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].addr, rows[i].data);
      end else begin
        rd(rows[i].addr, rows[i].data);
      end
    end
    wr(T2_LIMIT_A_OFS, 16'h0003);
    wr(T2_COUNT_OFS, 16'h0000);
    wr(T2_CONTROL_OFS, 16'he001);
    watch(2, 48);
    check("irq2_period", 16'h0004, 16'(irqs));
    rd(T2_CONTROL_OFS, 16'ha021);
    wr(T2_CONTROL_OFS, 16'h4020);
    wr(T2_CONTROL_OFS, 16'h0000);
    rd(T2_CONTROL_OFS, 16'h0000);
    access(1'b0, T2_COUNT_OFS, 16'h0000, w);
    repeat (20) tick();
    rd(T2_COUNT_OFS, w);
    wr(T2_LIMIT_A_OFS, 16'h0005);
    wr(T2_COUNT_OFS, 16'hfffd);
    wr(T2_CONTROL_OFS, 16'he000);
    watch(2, 27);
    w = 16'(irqs);
    watch(2, 4);
    check("rollover", 16'h0001, {w[7:0], 8'(irqs)});
    watch(2, 40);
    check("halted", 16'h0000, 16'(irqs));
    rd(T2_CONTROL_OFS, 16'h2020);
    level = 2'h2;
    wr(T1_LIMIT_A_OFS, 16'h0002);
    wr(T1_LIMIT_B_OFS, 16'h0003);
    wr(T1_COUNT_OFS, 16'h0000);
    wr(T1_CONTROL_OFS, 16'he002);
    watch(1, 60);
    check("dual_low", 16'h000c, 16'(lows));
    check("dual_irqs", 16'h0002, 16'(irqs));
    rd(T1_CONTROL_OFS, 16'h2022);
    level = 2'h0;
    wr(T0_LIMIT_A_OFS, 16'h0002);
    wr(T0_COUNT_OFS, 16'h0001);
    wr(T0_CONTROL_OFS, 16'hc001);
    rd(T0_CONTROL_OFS, 16'h8001);
    repeat (20) tick();
    rd(T0_COUNT_OFS, 16'h0001);
    level = 2'h1;
    watch(0, 80);
    check("pulses", 16'h0001, 16'(lows >= 9 && lows <= 10));
    level = 2'h0;
    wr(T0_LIMIT_A_OFS, 16'h0000);
    wr(T0_CONTROL_OFS, 16'hc005);
    wr(T0_COUNT_OFS, 16'h0000);
    pulse_en = 2'h1;
    repeat (40) tick();
    pulse_en = 2'h0;
    repeat (12) tick();
    rd(T0_COUNT_OFS, edge_count);
    wr(T0_CONTROL_OFS, 16'h4000);
    wr(T0_CONTROL_OFS, 16'hc011);
    wr(T0_COUNT_OFS, 16'h0100);
    repeat (20) tick();
    rd(T0_COUNT_OFS, 16'h0100);
    pulse_en = 2'h1;
    tick();
    pulse_en = 2'h0;
    repeat (12) tick();
    access(1'b0, T0_COUNT_OFS, 16'h0000, w);
    check("restart", 16'h0001, 16'(w < 16'h0008));
    level = 2'h2;
    wr(T1_LIMIT_A_OFS, 16'h0000);
    wr(T1_CONTROL_OFS, 16'hc009);
    wr(T2_LIMIT_A_OFS, 16'h0002);
    wr(T2_CONTROL_OFS, 16'hc001);
    repeat (80) tick();
    access(1'b0, T1_COUNT_OFS, 16'h0000, w);
    check("chain", 16'h0001, 16'(w - 16'h0009 < 16'h0002));
    wr(T2_COUNT_OFS, 16'h1000);
    access(1'b0, T2_COUNT_OFS, 16'h0000, w);
    check("live_write", 16'h0001, 16'(w - 16'h1000 < 16'h0002));
    resetn = 1'b0;
    repeat (2) tick();
    check("reset_pins", 16'h0003, {14'h0, timer_out});
    resetn = 1'b1;
    rd(T2_CONTROL_OFS, 16'h0000);
    rd(T0_CONTROL_OFS, 16'h0002);
    rd(T1_CONTROL_OFS, 16'h0002);
    finish_test();
  end
endmodule
